//--- rtl/dac_word_defs.vh
// Constants for the dual converter serial word decoder and its APB register file.
`ifndef DAC_WORD_DEFS_VH
`define DAC_WORD_DEFS_VH

// Serial command word layout.
`define WORD_W 16
`define CNT_W 5
`define LAST_BIT_CNT 5'h0F
`define SEL_HI_BIT 15
`define SPEED_BIT 14
`define PD_BIT 13
`define SEL_LO_BIT 12
`define CODE_MSB 11
`define CODE_LSB 2
`define CODE_W 10
`define CODE_ZERO 10'h000

// Target select codes built from the high and low select bits.
`define SEL_B_AND_BUF 2'h0
`define SEL_BUF_ONLY 2'h1
`define SEL_A_AND_XFER 2'h2
`define SEL_RESERVED 2'h3

// APB register map, byte addresses of aligned 32-bit words.
`define ADDR_W 8
`define REG_CTRL 8'h00
`define REG_CODE_A 8'h04
`define REG_CODE_B 8'h08
`define REG_HOLD 8'h0C
`define REG_STATUS 8'h10

// Control register fields and reset value.
`define CTRL_EN_BIT 0
`define CTRL_RESET 32'h0000_0001

// Status register fields.
`define ST_PD_BIT 0
`define ST_SPEED_BIT 1
`define ST_STATE_LSB 2
`define ST_STATE_MSB 3
`define ST_WORDS_LSB 16
`define ST_WORDS_MSB 31
`define WORDS_W 16
`define WORDS_ZERO 16'h0000
`define WORDS_ONE 16'h0001

// Common values.
`define DATA_ZERO 32'h0000_0000
`define PIN_SYNC_W 3

`endif

//--- rtl/pin_sync.v
// Two flip-flop synchroniser for a group of asynchronous pin inputs.
`timescale 1ns/1ps

module pin_sync #(
  parameter WIDTH = 1
) (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // First stage of this bit; only the second stage reads it.
      reg meta_reg;
      // Second stage, the settled copy used by the logic.
      reg stable_reg;
      // Each bit passes two flops; reset parks both at idle high.
      always @(posedge mclk_i) begin
        if (sys_rst_i) begin
          meta_reg <= 1'b1;
          stable_reg <= 1'b1;
        end else begin
          meta_reg <= async_i[i];
          stable_reg <= meta_reg;
        end
      end
      // The settled bit leaves the module directly from its flop.
      assign sync_o[i] = stable_reg;
    end
  endgenerate

endmodule

//--- rtl/dual_dac_serial_word_decoder.v
// Serial command word decoder for a dual 10-bit converter, with an APB status and control port.
//
// What this block does
// RULE1 - 16-bit word: select, speed, power-down, data fields.
// RULE2 - Code is bits 11..2; low two zero.
// RULE3 - Select 00 loads converter B and buffer.
// RULE4 - Select 01 loads only the holding buffer.
// RULE5 - Select 10 loads A, buffer copied into B.
// RULE6 - Select 11 reserved, nothing changes; the code still clears power-down and applies the speed bit.
// RULE7 - Speed bit one fast, zero slow, immediate.
// RULE8 - Output changes on rising clock after last bit.
// RULE9 - Buffered then select 10 updates both together.
// RULE10 - Host sends buffer word, then select 10 word.
// RULE11 - Power-down bit set: power down, ignore rest.
// RULE12 - Select fall starts; MSB first on falling clock.
// RULE13 - Sixteen bits or early select rise applies word.
// RULE14 - Host gives one extra rising clock afterwards.
// RULE15 - Reset clears all latches to zero.
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "dac_word_defs.vh"

module dual_dac_serial_word_decoder (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire cs_n_i,
  input wire sclk_i,
  input wire din_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [`ADDR_W-1:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output reg pslverr_o,
  output reg [`CODE_W-1:0] code_a_o,
  output reg [`CODE_W-1:0] code_b_o,
  output reg settle_fast_o,
  output reg power_down_o,
  output reg update_o
);

  // Receiver states.
  localparam ST_IDLE = 2'b00;
  localparam ST_SHIFT = 2'b01;
  localparam ST_PEND = 2'b10;
  localparam ST_DONE = 2'b11;

  // Settled copies of the three serial pins.
  wire [`PIN_SYNC_W-1:0] pins_sync;
  wire cs_n_s;
  wire sclk_s;
  wire din_s;

  // Previous settled levels, used to find pin edges.
  reg cs_n_prev_reg;
  reg sclk_prev_reg;

  // Edge strobes, each one mclk cycle long.
  wire cs_fall;
  wire cs_rise;
  wire sclk_fall;
  wire sclk_rise;

  // Receiver state, bit counter and shift register.
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [`CNT_W-1:0] cnt_reg;
  reg [`CNT_W-1:0] cnt_next;
  reg [`WORD_W-1:0] shift_reg;
  reg [`WORD_W-1:0] shift_next;

  // Holding buffer for the deferred converter B code.
  reg [`CODE_W-1:0] hold_reg;

  // Asserted in the cycle a received word is moved to the latches.
  reg apply;

  // Fields of the word being applied.
  wire [1:0] target_sel;
  wire settle_speed_sel;
  wire power_down_bit;
  wire [`CODE_W-1:0] new_code;

  // Software control and bookkeeping.
  reg [31:0] ctrl_reg;
  reg [`WORDS_W-1:0] words_reg;
  wire link_en;

  // APB decode strobes.
  wire apb_setup;
  wire apb_write;
  reg addr_hit;
  reg [31:0] rd_value;

  // The three pins are asynchronous, so they pass two flops first.
  pin_sync #(
    .WIDTH(`PIN_SYNC_W)
  ) u_pin_sync (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({cs_n_i, sclk_i, din_i}),
    .sync_o(pins_sync)
  );

  assign cs_n_s = pins_sync[2];
  assign sclk_s = pins_sync[1];
  assign din_s = pins_sync[0];

  // Keep one cycle of history on select and serial clock.
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cs_n_prev_reg <= 1'b1;
      sclk_prev_reg <= 1'b1;
    end else begin
      cs_n_prev_reg <= cs_n_s;
      sclk_prev_reg <= sclk_s;
    end
  end

  // Edges of the settled pins; serial clock falling edges count only while selected.
  assign cs_fall = cs_n_prev_reg & ~cs_n_s; // RULE12
  assign cs_rise = ~cs_n_prev_reg & cs_n_s;
  assign sclk_fall = sclk_prev_reg & ~sclk_s & ~cs_n_s; // RULE12
  assign sclk_rise = ~sclk_prev_reg & sclk_s;

  // The enable bit lets software hold the receiver off the link.
  assign link_en = ctrl_reg[`CTRL_EN_BIT];

  // Receiver sequencing: start, shift, wait for the closing edge, then idle.
  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    apply = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        // A select fall opens a new word with an empty counter.
        if (cs_fall && link_en) begin
          state_next = ST_SHIFT; // RULE12
          cnt_next = {`CNT_W{1'b0}};
          // Old bits are cleared so a short word lands right aligned over zeros.
          shift_next = {`WORD_W{1'b0}}; // RULE13
        end
      end
      ST_SHIFT: begin
        if (cs_rise) begin
          // An early select rise moves whatever arrived so far.
          apply = (cnt_reg != {`CNT_W{1'b0}}); // RULE13
          state_next = ST_IDLE;
        end else if (sclk_fall) begin
          // Shift in most significant bit first.
          shift_next = {shift_reg[`WORD_W-2:0], din_s}; // RULE12
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == `LAST_BIT_CNT) begin
            state_next = ST_PEND; // RULE13
          end
        end
      end
      ST_PEND: begin
        // The full word goes out on the next rising clock, or on select rise.
        if (sclk_rise || cs_rise) begin
          apply = 1'b1; // RULE8 RULE13
          state_next = cs_rise ? ST_IDLE : ST_DONE;
        end
      end
      ST_DONE: begin
        // Further clocks are ignored until select goes high again.
        if (cs_rise) begin
          state_next = ST_IDLE; // RULE14
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Receiver registers.
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_IDLE;
      cnt_reg <= {`CNT_W{1'b0}};
      shift_reg <= {`WORD_W{1'b0}}; // RULE15
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
    end
  end

  // Split the received word into its fields.
  assign target_sel = {shift_reg[`SEL_HI_BIT], shift_reg[`SEL_LO_BIT]}; // RULE1
  assign settle_speed_sel = shift_reg[`SPEED_BIT]; // RULE1
  assign power_down_bit = shift_reg[`PD_BIT]; // RULE1
  assign new_code = shift_reg[`CODE_MSB:`CODE_LSB]; // RULE2

  // Latch update: all latches move in the same mclk cycle, so B and A change together.
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      code_a_o <= `CODE_ZERO; // RULE15
      code_b_o <= `CODE_ZERO;
      hold_reg <= `CODE_ZERO;
      settle_fast_o <= 1'b0;
      power_down_o <= 1'b0;
      update_o <= 1'b0;
    end else begin
      update_o <= 1'b0;
      if (apply) begin
        update_o <= 1'b1;
        if (power_down_bit) begin
          // Power-down words touch nothing else.
          power_down_o <= 1'b1; // RULE11
        end else begin
          // Any other word wakes the device and sets its speed.
          power_down_o <= 1'b0;
          settle_fast_o <= settle_speed_sel; // RULE7
          case (target_sel)
            `SEL_B_AND_BUF: begin
              code_b_o <= new_code; // RULE3
              hold_reg <= new_code;
            end
            `SEL_BUF_ONLY: begin
              hold_reg <= new_code; // RULE4
            end
            `SEL_A_AND_XFER: begin
              // A and the buffered B code update in one cycle.
              code_a_o <= new_code; // RULE5 RULE9
              code_b_o <= hold_reg;
            end
            default: begin
              // Reserved select leaves both codes and the buffer as they were.
              hold_reg <= hold_reg; // RULE6
            end
          endcase
        end
      end
    end
  end

  // Count applied words so software can see link activity.
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      words_reg <= `WORDS_ZERO;
    end else if (apply) begin
      words_reg <= words_reg + `WORDS_ONE;
    end
  end

  // APB phases; the slave never inserts wait states.
  assign apb_setup = psel_i & ~penable_i;
  assign apb_write = psel_i & penable_i & pwrite_i;
  assign pready_o = 1'b1;

  // Address decode and read multiplexer.
  always @* begin
    addr_hit = 1'b1;
    rd_value = `DATA_ZERO;
    case (paddr_i)
      `REG_CTRL: begin
        rd_value = ctrl_reg;
      end
      `REG_CODE_A: begin
        rd_value[`CODE_W-1:0] = code_a_o;
      end
      `REG_CODE_B: begin
        rd_value[`CODE_W-1:0] = code_b_o;
      end
      `REG_HOLD: begin
        rd_value[`CODE_W-1:0] = hold_reg;
      end
      `REG_STATUS: begin
        rd_value[`ST_PD_BIT] = power_down_o;
        rd_value[`ST_SPEED_BIT] = settle_fast_o;
        rd_value[`ST_STATE_MSB:`ST_STATE_LSB] = state_reg;
        rd_value[`ST_WORDS_MSB:`ST_WORDS_LSB] = words_reg;
      end
      default: begin
        // Unmapped addresses read zero and flag an error.
        addr_hit = 1'b0;
      end
    endcase
  end

  // Read data and error are captured in the setup cycle for the access cycle.
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      prdata_o <= `DATA_ZERO;
      pslverr_o <= 1'b0;
    end else if (apb_setup) begin
      prdata_o <= pwrite_i ? `DATA_ZERO : rd_value;
      pslverr_o <= ~addr_hit;
    end
  end

  // Only the control register is writable; other writes are dropped.
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= `CTRL_RESET;
    end else if (apb_write && (paddr_i == `REG_CTRL)) begin
      ctrl_reg <= {31'h0000_0000, pwdata_i[`CTRL_EN_BIT]};
    end
  end

endmodule

//--- testbench/dac_host_model.sv
// Host serial port model that drives select, serial clock and data.
`timescale 1ns/1ps
module dac_host_model (
  output logic cs_n_o,
  output logic sclk_o,
  output logic din_o
);
  // The serial clock rests high outside frames.
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
    din_o = 1'b1;
  end
  // Shifts the top n bits of v out MSB first at 32 ns per bit.
  task automatic send(input logic [15:0] v, input int n);
    #3.3 cs_n_o = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      din_o = v[i];
      #16 sclk_o = 1'b0;
      #16 sclk_o = 1'b1;
    end
    // A released data line must not keep showing the last bit.
    din_o = ~din_o;
    #16 cs_n_o = 1'b1;
    #40;
  endtask
endmodule

//--- testbench/dual_dac_serial_word_decoder_asserts.sv
// Checker for the converter outputs of the serial word decoder.
`timescale 1ns/1ps
module dac_decoder_asserts (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire [9:0] code_a_o,
  input wire [9:0] code_b_o,
  input wire settle_fast_o,
  input wire power_down_o,
  input wire update_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  a_reset_clears: assert property (disable iff (1'b0) sys_rst_i |=>
    code_a_o == 10'h000 && code_b_o == 10'h000 && !power_down_o && !settle_fast_o && !update_o)
    else $error("outputs not cleared by reset");
  a_update_single: assert property (update_o |=> !update_o [*8])
    else $error("update pulse too long or repeated");
  a_code_a_moves: assert property (!$stable(code_a_o) |-> update_o)
    else $error("code A changed without an update");
  a_code_b_moves: assert property (!$stable(code_b_o) |-> update_o)
    else $error("code B changed without an update");
  a_speed_moves: assert property (!$stable(settle_fast_o) |-> update_o)
    else $error("speed changed without an update");
  a_pd_moves: assert property (!$stable(power_down_o) |-> update_o)
    else $error("power down changed without an update");
  a_pd_keeps_codes: assert property (update_o && power_down_o |->
    $stable(code_a_o) && $stable(code_b_o))
    else $error("power down word moved a code");
  a_pd_keeps_speed: assert property (update_o && power_down_o |-> $stable(settle_fast_o))
    else $error("power down word moved the speed");
  c_pd_word: cover property (update_o && power_down_o);
  c_both_move: cover property (!$stable(code_a_o) && !$stable(code_b_o));
  c_a_only: cover property (!$stable(code_a_o) && $stable(code_b_o));
endmodule
bind dual_dac_serial_word_decoder dac_decoder_asserts u_asserts (
  .mclk_i, .sys_rst_i, .code_a_o, .code_b_o, .settle_fast_o, .power_down_o, .update_o
);

//--- testbench/dual_dac_serial_word_decoder_tb.sv
// Self-checking bench for the serial word decoder.
`timescale 1ns/1ps
`include "dac_word_defs.vh"
module dual_dac_serial_word_decoder_tb;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  wire cs_n_i, sclk_i, din_i, pready_o, pslverr_o, settle_fast_o, power_down_o, update_o;
  wire [31:0] prdata_o;
  wire [9:0] code_a_o, code_b_o;
  logic [31:0] rd;
  logic err;
  // Expected converter A, converter B and holding buffer codes.
  logic [9:0] ea = 10'h000, eb = 10'h000, eh = 10'h000;
  logic ef = 1'b0, ep = 1'b0, en = 1'b1;
  logic [15:0] w;
  int seed = 64;
  int num_errors = 0;
  int comparisons = 0;
  // Expected count of applied words.
  int nw = 0;
  always #2 mclk_i = ~mclk_i;
  dac_host_model host (.cs_n_o(cs_n_i), .sclk_o(sclk_i), .din_o(din_i));
  dual_dac_serial_word_decoder dut (.mclk_i, .sys_rst_i, .cs_n_i, .sclk_i, .din_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .code_a_o, .code_b_o, .settle_fast_o, .power_down_o, .update_o);
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data is taken at the edge that sees pready.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // Works out the latch contents after a completed word.
  task automatic expect_word(input logic [15:0] v);
    if (en) begin
      nw++;
      ep = v[13];
      if (!v[13]) ef = v[14];
      if (!v[13] && {v[15], v[12]} != 2'h3) begin
        if ({v[15], v[12]} == 2'h2) begin
          eb = eh;
          ea = v[11:2];
        end else begin
          if (!v[12]) eb = v[11:2];
          eh = v[11:2];
        end
      end
    end
  endtask
  task automatic check_all;
    @(posedge mclk_i);
    chk(32'(code_a_o), 32'(ea));
    chk(32'(code_b_o), 32'(eb));
    chk(32'(settle_fast_o), 32'(ef));
    chk(32'(power_down_o), 32'(ep));
    apb(1'b0, `REG_HOLD, 32'h0000_0000);
    chk(rd, 32'(eh));
    apb(1'b0, `REG_CODE_B, 32'h0000_0000);
    chk(rd, 32'(eb));
    apb(1'b0, `REG_STATUS, 32'h0000_0000);
    chk(rd, {16'(nw), 14'h0000, ef, ep});
  endtask
  // Sends n bits, a short word applying right aligned.
  task automatic word(input logic [15:0] v, input int n);
    host.send(v, n);
    expect_word(v >> (16 - n));
    check_all;
  endtask
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Main sequence: every select code, a partial word, link off, a second reset.
  initial begin
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    check_all;
    for (int i = 0; i < 16; i++) begin
      w = 16'($random(seed));
      w[1:0] = 2'h0;
      w[13] = (i == 9);
      {w[15], w[12]} = 2'(i);
      word(w, 16);
    end
    apb(1'b0, `REG_CODE_A, 32'h0000_0000);
    chk(rd, 32'(ea));
    word(16'($random(seed)), 8);
    apb(1'b1, `REG_CTRL, 32'h0000_0000);
    en = 1'b0;
    word(16'h8FFC, 16);
    apb(1'b1, `REG_CTRL, 32'h0000_0001);
    en = 1'b1;
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    {ea, eb, eh, ef, ep} = 32'h0000_0000;
    nw = 0;
    check_all;
    word(16'hC554, 16);
    tally_and_finish;
  end
  // Watchdog against a hung run.
  initial begin
    #100000;
    num_errors++;
    tally_and_finish;
  end
endmodule
